// >>> pmc_pkg.sv
// package: register map, field positions, reset values and timing for power mode control
package pmc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] PMC_CTRL_OFFSET = 8'h84;
	localparam int PMC_MODE_HI = 31;
	localparam int PMC_MODE_LO = 29;
	localparam int PMC_SLEEP_BIT = 28;
	localparam int PMC_AUTO_WAKE_BIT = 27;
	localparam int PMC_IND_DIS_BIT = 26;
	localparam int PMC_CLK_GATE_BIT = 21;
	localparam int PMC_STS_B_BIT = 17;
	localparam int PMC_STS_A_BIT = 16;
	localparam int PMC_EN_B_BIT = 15;
	localparam int PMC_EN_A_BIT = 14;
	localparam int PMC_READY_BIT = 0;

	// ------------------------------------------------------------
	// reset values and encodings
	// ------------------------------------------------------------
	localparam logic [2:0] PMC_MODE_RESET = 3'h0;
	localparam logic [2:0] PMC_FULL_POWER_STATE = 3'h0;
	localparam logic [2:0] PMC_LIGHT_SLEEP_STATE = 3'h1;
	localparam logic [2:0] PMC_DEEPER_SLEEP_STATE = 3'h2;
	localparam logic [2:0] PMC_DEEPEST_SLEEP_STATE = 3'h3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int PMC_CLK_MHZ = 200;
	localparam int PMC_WAKE_MAX_US = 2000;
	localparam int PMC_WAKE_MAX_CYC = PMC_WAKE_MAX_US * PMC_CLK_MHZ;
	localparam int PMC_PLL_SETTLE_CYC = 64;

	typedef enum logic [3:0] {
		PMC_ST_RUN = 4'h1,
		PMC_ST_SLEEP = 4'h2,
		PMC_ST_WAKE = 4'h4,
		PMC_ST_SETTLE = 4'h8
	} pmc_state_t;

endpackage

// >>> pmc_sync.sv
// module: three-stage input synchroniser with agreement of the last two stages
module pmc_sync
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	// data
	input wire logic i_async,
	output logic o_sync
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// first stage is read only by the second
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			o_sync <= 1'b0;
		end
		else if (i_ce)
		begin
			s1_reg <= i_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
			begin
				o_sync <= s3_reg;
			end
		end
	end

endmodule // pmc_sync

// >>> pmc_ctrl.sv
// module: power management control register and sleep sequencer
module pmc_ctrl
#(
	parameter int WAKE_MAX_CYC = pmc_pkg::PMC_WAKE_MAX_CYC,
	parameter int PLL_SETTLE_CYC = pmc_pkg::PMC_PLL_SETTLE_CYC,
	parameter int N_IND = 4
)
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic i_wr,
	input wire logic [3:0] i_be,
	input wire logic [31:0] i_wdata,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// phy events (pins) and wake sources
	input wire logic i_port_a_event,
	input wire logic i_port_b_event,
	input wire logic i_manual_wake,
	input wire logic i_pll_locked,
	input wire logic i_irq_flag_clear,
	// indicators
	input wire logic [N_IND-1:0] i_ind_value,
	input wire logic [N_IND-1:0] i_ind_push_pull,
	input wire logic [N_IND-1:0] i_ind_active_high,
	output logic [N_IND-1:0] o_ind_out,
	output logic [N_IND-1:0] o_ind_oe,
	// power outputs
	output logic o_core_clk_en,
	output logic o_sleeping,
	output logic [2:0] o_sleep_state,
	output logic o_wake_event_irq_flag,
	output logic o_device_ready
);

	// ------------------------------------------------------------
	// register fields
	// ------------------------------------------------------------
	logic [2:0] sleep_state_select_reg;
	logic sleep_request_reg;
	logic auto_wake_enable_reg;
	logic indicator_disable_reg;
	logic core_clock_gate_reg;
	logic gate_first_one_reg;
	logic port_a_wake_status_reg;
	logic port_b_wake_status_reg;
	logic port_a_wake_enable_reg;
	logic port_b_wake_enable_reg;
	logic ready_reg;
	logic wake_irq_reg;
	pmc_pkg::pmc_state_t state_reg;
	logic [31:0] cnt_reg;
	logic ev_a;
	logic ev_b;
	logic ev_a_d_reg;
	logic ev_b_d_reg;
	logic wake_done;
	logic wake_start;
	logic hit_wr;
	logic sel_wr;
	logic req_wr;
	logic [2:0] new_sel;
	logic [31:0] wake_cyc_reg;

	pmc_sync u_sync_a
	(
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_async(i_port_a_event),
		.o_sync(ev_a)
	);

	pmc_sync u_sync_b
	(
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_async(i_port_b_event),
		.o_sync(ev_b)
	);

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	assign hit_wr = i_ce && i_wr && (i_addr == pmc_pkg::PMC_CTRL_OFFSET);
	assign new_sel = i_wdata[pmc_pkg::PMC_MODE_HI:pmc_pkg::PMC_MODE_LO];
	// select written with sleep request one is dropped
	assign sel_wr = hit_wr && i_be[3] && !i_wdata[pmc_pkg::PMC_SLEEP_BIT];
	// request dropped if the same write changes the select field
	assign req_wr = hit_wr && i_be[3] && i_wdata[pmc_pkg::PMC_SLEEP_BIT]
		&& (new_sel == sleep_state_select_reg);
	assign wake_done = (state_reg == pmc_pkg::PMC_ST_SETTLE) && (cnt_reg == 32'h0)
		&& i_pll_locked;
	// deepest state wakes manually only
	assign wake_start = (state_reg == pmc_pkg::PMC_ST_SLEEP) && (i_manual_wake
		|| (auto_wake_enable_reg && wake_irq_reg
		&& (sleep_state_select_reg != pmc_pkg::PMC_DEEPEST_SLEEP_STATE)));

	// ------------------------------------------------------------
	// sleep select and request
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			sleep_state_select_reg <= pmc_pkg::PMC_MODE_RESET;
			sleep_request_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			if (wake_done)
			begin
				sleep_state_select_reg <= pmc_pkg::PMC_MODE_RESET;
				sleep_request_reg <= 1'b0;
			end
			else
			begin
				if (sel_wr)
				begin
					sleep_state_select_reg <= new_sel;
				end
				// full-power code is not blocked here
				if (req_wr)
				begin
					sleep_request_reg <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// other control bits
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			auto_wake_enable_reg <= 1'b0;
			indicator_disable_reg <= 1'b0;
			core_clock_gate_reg <= 1'b0;
			gate_first_one_reg <= 1'b0;
			port_a_wake_enable_reg <= 1'b0;
			port_b_wake_enable_reg <= 1'b0;
		end
		else if (hit_wr)
		begin
			if (i_be[3])
			begin
				auto_wake_enable_reg <= i_wdata[pmc_pkg::PMC_AUTO_WAKE_BIT];
				indicator_disable_reg <= i_wdata[pmc_pkg::PMC_IND_DIS_BIT];
			end
			if (i_be[2])
			begin
				// zero clears and resets the count; two ones in a row needed
				if (!i_wdata[pmc_pkg::PMC_CLK_GATE_BIT])
				begin
					core_clock_gate_reg <= 1'b0;
					gate_first_one_reg <= 1'b0;
				end
				else if (gate_first_one_reg)
				begin
					core_clock_gate_reg <= 1'b1;
				end
				else
				begin
					gate_first_one_reg <= 1'b1;
				end
			end
			if (i_be[1])
			begin
				port_b_wake_enable_reg <= i_wdata[pmc_pkg::PMC_EN_B_BIT];
				port_a_wake_enable_reg <= i_wdata[pmc_pkg::PMC_EN_A_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// wake status and irq flag
	// ------------------------------------------------------------
	// level events: a status clear while the phy still holds the event is overridden
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			port_a_wake_status_reg <= 1'b0;
			port_b_wake_status_reg <= 1'b0;
			wake_irq_reg <= 1'b0;
			ev_a_d_reg <= 1'b0;
			ev_b_d_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			ev_a_d_reg <= ev_a;
			ev_b_d_reg <= ev_b;
			if (ev_a)
			begin
				port_a_wake_status_reg <= 1'b1;
			end
			else if (hit_wr && i_be[2] && i_wdata[pmc_pkg::PMC_STS_A_BIT])
			begin
				port_a_wake_status_reg <= 1'b0;
			end
			if (ev_b)
			begin
				port_b_wake_status_reg <= 1'b1;
			end
			else if (hit_wr && i_be[2] && i_wdata[pmc_pkg::PMC_STS_B_BIT])
			begin
				port_b_wake_status_reg <= 1'b0;
			end
			if ((ev_a && !ev_a_d_reg && port_a_wake_enable_reg)
				|| (ev_b && !ev_b_d_reg && port_b_wake_enable_reg))
			begin
				wake_irq_reg <= 1'b1;
			end
			else if (i_irq_flag_clear)
			begin
				wake_irq_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// power sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_reg <= pmc_pkg::PMC_ST_SETTLE;
			cnt_reg <= 32'h0;
			ready_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			unique case (state_reg)
				pmc_pkg::PMC_ST_RUN:
				begin
					if (sleep_request_reg)
					begin
						state_reg <= pmc_pkg::PMC_ST_SLEEP;
						ready_reg <= 1'b0;
					end
				end
				pmc_pkg::PMC_ST_SLEEP:
				begin
					if (wake_start)
					begin
						state_reg <= pmc_pkg::PMC_ST_WAKE;
					end
				end
				pmc_pkg::PMC_ST_WAKE:
				begin
					state_reg <= pmc_pkg::PMC_ST_SETTLE;
					cnt_reg <= 32'(PLL_SETTLE_CYC);
				end
				pmc_pkg::PMC_ST_SETTLE:
				begin
					// pll must report lock; settle bounded well inside wake limit
					if (cnt_reg != 32'h0)
					begin
						cnt_reg <= cnt_reg - 32'h1;
					end
					else if (i_pll_locked)
					begin
						state_reg <= pmc_pkg::PMC_ST_RUN;
						ready_reg <= 1'b1;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// read and outputs
	// ------------------------------------------------------------
	// reads are side-effect free, so any byte subset or sleep state is safe
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_rdata <= 32'h0;
		end
		else if (i_ce && i_rd)
		begin
			o_rdata <= 32'h0;
			if (i_addr == pmc_pkg::PMC_CTRL_OFFSET)
			begin
				o_rdata[pmc_pkg::PMC_MODE_HI:pmc_pkg::PMC_MODE_LO] <= sleep_state_select_reg;
				o_rdata[pmc_pkg::PMC_SLEEP_BIT] <= sleep_request_reg;
				o_rdata[pmc_pkg::PMC_AUTO_WAKE_BIT] <= auto_wake_enable_reg;
				o_rdata[pmc_pkg::PMC_IND_DIS_BIT] <= indicator_disable_reg;
				o_rdata[pmc_pkg::PMC_CLK_GATE_BIT] <= core_clock_gate_reg;
				o_rdata[pmc_pkg::PMC_STS_B_BIT] <= port_b_wake_status_reg;
				o_rdata[pmc_pkg::PMC_STS_A_BIT] <= port_a_wake_status_reg;
				o_rdata[pmc_pkg::PMC_EN_B_BIT] <= port_b_wake_enable_reg;
				o_rdata[pmc_pkg::PMC_EN_A_BIT] <= port_a_wake_enable_reg;
				o_rdata[pmc_pkg::PMC_READY_BIT] <= ready_reg;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_core_clk_en <= 1'b1;
			o_sleeping <= 1'b0;
			o_sleep_state <= pmc_pkg::PMC_FULL_POWER_STATE;
			o_wake_event_irq_flag <= 1'b0;
			o_device_ready <= 1'b0;
		end
		else if (i_ce)
		begin
			o_core_clk_en <= !core_clock_gate_reg;
			o_sleeping <= (state_reg == pmc_pkg::PMC_ST_SLEEP);
			o_sleep_state <= (state_reg == pmc_pkg::PMC_ST_SLEEP) ? sleep_state_select_reg
				: pmc_pkg::PMC_FULL_POWER_STATE;
			o_wake_event_irq_flag <= wake_irq_reg;
			o_device_ready <= ready_reg;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < N_IND; gi++)
		begin : g_ind
			always_ff @(posedge i_sys_clk or negedge i_rst_b)
			begin
				if (!i_rst_b)
				begin
					o_ind_out[gi] <= 1'b0;
					o_ind_oe[gi] <= 1'b0;
				end
				else if (i_ce)
				begin
					// disabled push-pull drives inactive level, open types float
					o_ind_out[gi] <= indicator_disable_reg ? !i_ind_active_high[gi]
						: i_ind_value[gi];
					o_ind_oe[gi] <= indicator_disable_reg ? i_ind_push_pull[gi]
						: (i_ind_push_pull[gi] || i_ind_value[gi]);
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_gate_two;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(core_clock_gate_reg) |-> $past(gate_first_one_reg);
	endproperty
	a_gate_two: assert property (p_gate_two) else $error("gate set without two ones");

	property p_sel_ignored;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(hit_wr && i_be[3] && i_wdata[pmc_pkg::PMC_SLEEP_BIT] && !wake_done)
		|=> $stable(sleep_state_select_reg);
	endproperty
	a_sel_ignored: assert property (p_sel_ignored) else $error("select changed");

	property p_req_ignored;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(hit_wr && i_be[3] && (new_sel != sleep_state_select_reg) && !sleep_request_reg)
		|=> !sleep_request_reg;
	endproperty
	a_req_ignored: assert property (p_req_ignored) else $error("request taken");

	property p_ready_low_sleep;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state_reg == pmc_pkg::PMC_ST_SLEEP) |-> !ready_reg;
	endproperty
	a_ready_low_sleep: assert property (p_ready_low_sleep) else $error("ready in sleep");

	property p_wake_clears;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && wake_done) |=> (!sleep_request_reg && sleep_state_select_reg == 3'h0 && ready_reg);
	endproperty
	a_wake_clears: assert property (p_wake_clears) else $error("wake did not clear");

	property p_clk_gate;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_ce |=> (o_core_clk_en == !$past(core_clock_gate_reg));
	endproperty
	a_clk_gate: assert property (p_clk_gate) else $error("core clock mismatch");

	property p_sts_a;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && ev_a) |=> port_a_wake_status_reg;
	endproperty
	a_sts_a: assert property (p_sts_a) else $error("port a status not set");

	property p_sts_b;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && ev_b) |=> port_b_wake_status_reg;
	endproperty
	a_sts_b: assert property (p_sts_b) else $error("port b status not set");

	property p_irq_en;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && ev_a && !ev_a_d_reg && port_a_wake_enable_reg) |=> wake_irq_reg;
	endproperty
	a_irq_en: assert property (p_irq_en) else $error("irq flag not set");

	property p_auto_wake;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && state_reg == pmc_pkg::PMC_ST_SLEEP && auto_wake_enable_reg && wake_irq_reg
		&& sleep_state_select_reg != 3'h3) |=> (state_reg == pmc_pkg::PMC_ST_WAKE);
	endproperty
	a_auto_wake: assert property (p_auto_wake) else $error("auto wake missed");

	property p_irq_en_b;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && ev_b && !ev_b_d_reg && port_b_wake_enable_reg) |=> wake_irq_reg;
	endproperty
	a_irq_en_b: assert property (p_irq_en_b) else $error("port b irq flag not set");

	// cycles spent between sleep and run; a pll that never locks trips this
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wake_cyc_reg <= 32'h0;
		end
		else if (i_ce)
		begin
			if ((state_reg == pmc_pkg::PMC_ST_RUN) || (state_reg == pmc_pkg::PMC_ST_SLEEP))
			begin
				wake_cyc_reg <= 32'h0;
			end
			else
			begin
				wake_cyc_reg <= wake_cyc_reg + 32'h1;
			end
		end
	end

	property p_wake_bound;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		wake_cyc_reg < 32'(WAKE_MAX_CYC);
	endproperty
	a_wake_bound: assert property (p_wake_bound) else $error("wake took too long");

endmodule // pmc_ctrl

// >>> pmc_host_model.sv
// host bus master model for the power mode control register
module pmc_host_model
(
	// clock
	input wire logic i_sys_clk,
	// register port
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic [3:0] o_be,
	output logic [31:0] o_wdata,
	output logic o_rd,
	input wire logic [31:0] i_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// bus cycles
	// ----
	initial
	begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_be = 4'h0;
		o_wdata = 32'h0;
		o_rd = 1'b0;
	end
	// released address and data invert and strobes drop, so a stale value is never mistaken for a live one
	task automatic rel();
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge i_sys_clk);
		#1;
		o_addr = a;
		o_be = be;
		o_wdata = d;
		o_wr = 1'b1;
		@(posedge i_sys_clk);
		#1;
		rel();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_sys_clk);
		#1;
		o_addr = a;
		o_rd = 1'b1;
		@(posedge i_sys_clk);
		#1;
		d = i_rdata;
		rel();
	endtask
endmodule // pmc_host_model

// >>> tb_power_mode_control_reg.sv
// testbench for the power mode control register block
module tb_power_mode_control_reg;
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// signals and reference state
	// ----
	logic clk, rst_b, ev_a, ev_b, mwake, pll, irq_clr, wr, rd;
	logic [7:0] addr;
	logic [3:0] be, ind_v, ind_pp, ind_ah, ind_out, ind_oe;
	logic [31:0] wdata, rdata, got;
	logic clk_en, sleeping, irqf, ready, ce;
	logic [2:0] sstate, m_mode;
	logic m_sleep, m_auto, m_ind, m_gate, sts_a, sts_b, en_a, en_b, m_irq, m_rdy;
	int mismatches, n_compared, k, m, i, g_cnt;

	pmc_ctrl #(.WAKE_MAX_CYC(1000), .PLL_SETTLE_CYC(8), .N_IND(4)) i_pmc_ctrl (
		.i_sys_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_addr(addr), .i_wr(wr),
		.i_be(be), .i_wdata(wdata), .i_rd(rd), .o_rdata(rdata), .i_port_a_event(ev_a),
		.i_port_b_event(ev_b), .i_manual_wake(mwake), .i_pll_locked(pll),
		.i_irq_flag_clear(irq_clr), .i_ind_value(ind_v), .i_ind_push_pull(ind_pp),
		.i_ind_active_high(ind_ah), .o_ind_out(ind_out), .o_ind_oe(ind_oe),
		.o_core_clk_en(clk_en), .o_sleeping(sleeping), .o_sleep_state(sstate),
		.o_wake_event_irq_flag(irqf), .o_device_ready(ready));
	pmc_host_model i_host (.i_sys_clk(clk), .o_addr(addr), .o_wr(wr), .o_be(be),
		.o_wdata(wdata), .o_rd(rd), .i_rdata(rdata));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ----
	// checks and reference model
	// ----
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rchk();
		i_host.rd(8'h84, got);
		chk(got, {m_mode, m_sleep, m_auto, m_ind, 4'h0, m_gate, 3'h0, sts_b, sts_a, en_b,
			en_a, 13'h0, m_rdy});
	endtask
	task automatic wr_m(input logic [3:0] b, input logic [31:0] d);
		i_host.wr(8'h84, b, d);
		if (b[3])
		begin
			if (!d[28]) m_mode = d[31:29];
			else if (d[31:29] == m_mode) {m_sleep, m_rdy} = 2'b10;
			{m_auto, m_ind} = d[27:26];
		end
		if (b[2])
		begin
			g_cnt = d[21] ? g_cnt + 1 : 0;
			m_gate = (g_cnt >= 2);
			if (d[17] && !ev_b) sts_b = 1'b0;
			if (d[16] && !ev_a) sts_a = 1'b0;
		end
		if (b[1]) {en_b, en_a} = d[15:14];
	endtask
	task automatic sleep_req(input logic [2:0] md);
		if (md == 3'h0) return;
		wr_m(4'h8, {md, 1'b0, m_auto, m_ind, 26'h0});
		wr_m(4'h8, {md, 1'b1, m_auto, m_ind, 26'h0});
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	initial
	begin
		{rst_b, ev_a, ev_b, mwake, irq_clr, m_sleep, m_auto, m_ind} = 8'h0;
		{ind_v, ind_pp, ind_ah, m_mode} = 15'h0;
		{m_gate, sts_a, sts_b, en_a, en_b, m_irq} = 6'h0;
		{pll, m_rdy, ce} = 3'b111;
		{mismatches, n_compared, g_cnt} = '0;
		void'($urandom(32'hbd00));
		repeat (5) @(posedge clk);
		chk({30'h0, ready, clk_en}, 32'h1);
		#1 rst_b = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		rchk();
		i_host.rd(8'h80, got);
		chk(got, 32'h0);
		wr_m(4'hf, 32'hefffffff);
		rchk();
		wr_m(4'h4, 32'h00200000);
		rchk();
		chk({31'h0, clk_en}, 32'h0);
		for (i = 0; i < 4; i++) wr_m(4'h4, {10'h0, i[0], 21'h0});
		rchk();
		chk({31'h0, clk_en}, 32'h1);
		wr_m(4'h8, 32'h50000000);
		rchk();
		wr_m(4'h8, 32'h08000000);
		for (m = 1; m < 4; m++)
		begin
			sleep_req(m[2:0]);
			for (k = 0; k < 20 && sleeping !== 1'b1; k++) @(posedge clk);
			#1;
			chk({27'h0, sleeping, ready, sstate}, {27'h0, 2'b10, m[2:0]});
			rchk();
			{pll, ev_a, sts_a, m_irq} = 4'b0111;
			repeat (30) @(posedge clk);
			#1;
			chk({29'h0, sleeping, irqf, ready}, {29'h0, m == 3, 2'b10});
			if (m == 3)
			begin
				mwake = 1'b1;
				@(posedge clk);
				#1 mwake = 1'b0;
			end
			repeat (20) @(posedge clk);
			#1;
			chk({31'h0, ready}, 32'h0);
			pll = 1'b1;
			for (k = 0; k < 400 && ready !== 1'b1; k++) @(posedge clk);
			#1;
			{m_mode, m_sleep, m_rdy} = 5'h01;
			chk({31'h0, ready}, 32'h1);
			rchk();
			ev_a = 1'b0;
			repeat (10) @(posedge clk);
			wr_m(4'h4, 32'h00010000);
			irq_clr = 1'b1;
			@(posedge clk);
			#1 {irq_clr, m_irq} = 2'b00;
			rchk();
			chk({31'h0, irqf}, 32'h0);
		end
		wr_m(4'h2, 32'h0);
		{ev_b, sts_b} = 2'b11;
		repeat (10) @(posedge clk);
		chk({31'h0, irqf}, 32'h0);
		wr_m(4'h4, 32'h00020000);
		rchk();
		ev_b = 1'b0;
		repeat (10) @(posedge clk);
		wr_m(4'h4, 32'h00020000);
		rchk();
		wr_m(4'h2, 32'h00008000);
		{ev_b, sts_b} = 2'b11;
		repeat (10) @(posedge clk);
		chk({31'h0, irqf}, 32'h1);
		rchk();
		// frozen clock enable: an event pulse and a write must leave no trace
		{ce, ev_a} = 2'b01;
		i_host.wr(8'h84, 4'h2, 32'h0);
		repeat (10) @(posedge clk);
		#1 ev_a = 1'b0;
		repeat (5) @(posedge clk);
		#1 ce = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		rchk();
		chk({30'h0, irqf, ready}, 32'h3);
		for (i = 0; i < 4; i++)
		begin
			{ind_v, ind_pp, ind_ah} = 12'($urandom());
			wr_m(4'h8, {5'h0, i[0], 26'h0});
			repeat (3) @(posedge clk);
			#1;
			if (i[0])
				chk({24'h0, ind_oe, ind_out & ind_pp}, {24'h0, ind_pp, ~ind_ah & ind_pp});
			else
				chk({24'h0, ind_oe, ind_out}, {24'h0, ind_pp | ind_v, ind_v});
		end
		finish_test();
	end
	// hang guard, far beyond the few hundred cycles the scenarios need
	initial
	begin
		#250000;
		mismatches++;
		finish_test();
	end
endmodule // tb_power_mode_control_reg
